/* pcrc_pkg.sv */
// shared constants and types for the core clock and reset control block
package pcrc_pkg;
  // reference clock selection codes
  localparam logic [1:0] REFCLK_CODE_100 = 2'h0;
  localparam logic [1:0] REFCLK_CODE_125 = 2'h1;
  localparam logic [1:0] REFCLK_CODE_250 = 2'h2;
  localparam int REFCLK_MHZ_100 = 100;
  localparam int REFCLK_MHZ_125 = 125;
  localparam int REFCLK_MHZ_250 = 250;
  // release synchronizer depth for the core and application resets
  localparam int RST_SYNC_STAGES = 2;
  // reset value of reset-type outputs
  localparam logic RST_ASSERTED = 1'h1;

  // link bring-up states
  typedef enum logic [1:0] {
    PCRC_ST_RESET = 2'h0,
    PCRC_ST_TRAIN = 2'h1,
    PCRC_ST_ACTIVE = 2'h2
  } pcrc_state_t;
endpackage : pcrc_pkg

/* pcrc_core.sv */
// clock and reset control for an integrated serial endpoint core
`timescale 1ns/1ps
module pcrc_core #(
  parameter int REFCLK_MHZ = 100,
  parameter bit SLOT_CLOCK_CFG = 1'b1,
  parameter bit NONSYNC_CLOCKING_OPTION = 1'b0,
  parameter int XCVR_LANES = 4
) (
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  input wire logic FUND_RST_N_IN,
  input wire logic CORE_PLL_LOCK_IN,
  input wire logic [XCVR_LANES-1:0] XCVR_PLL_LOCK_IN,
  input wire logic LINK_UP_IN,
  input wire logic INBAND_RST_IN,
  output logic CORE_RST_OUT,
  output logic APP_RST_OUT,
  output logic INBAND_RST_OUT,
  output logic LINK_TRAIN_OUT,
  output logic LINK_ACTIVE_OUT,
  output logic SLOT_CLK_STAT_OUT,
  output logic ASPM_ALLOWED_OUT,
  output logic [1:0] REFCLK_CODE_OUT
);

  // maps the configured frequency to its selection code
  function automatic logic [1:0] refclk_code(input int mhz);
    case (mhz)
      pcrc_pkg::REFCLK_MHZ_125: refclk_code = pcrc_pkg::REFCLK_CODE_125;
      pcrc_pkg::REFCLK_MHZ_250: refclk_code = pcrc_pkg::REFCLK_CODE_250;
      default: refclk_code = pcrc_pkg::REFCLK_CODE_100;
    endcase
  endfunction : refclk_code

  localparam int NS = pcrc_pkg::RST_SYNC_STAGES;

  logic [NS-1:0] core_rst_q;
  logic [NS-1:0] app_rst_q;
  logic app_cause;
  logic [1:0] link_up_q;
  logic [1:0] inband_q;
  logic inband_rst_q;
  logic train_q;
  logic active_q;
  logic slot_q;
  logic aspm_q;
  logic [1:0] refclk_q;
  pcrc_pkg::pcrc_state_t state_q;

  // every reason but SRST_IN to hold the application in reset; pin levels act at once
  assign app_cause = !FUND_RST_N_IN || !CORE_PLL_LOCK_IN || !(&XCVR_PLL_LOCK_IN);

  // core hard reset: set by the pin at once, cleared through a shift chain
  always_ff @(posedge MCLK_IN or negedge FUND_RST_N_IN) begin
    if (!FUND_RST_N_IN) begin
      core_rst_q <= {NS{pcrc_pkg::RST_ASSERTED}};
    end else if (SRST_IN) begin
      core_rst_q <= {NS{pcrc_pkg::RST_ASSERTED}};
    end else begin
      core_rst_q <= {core_rst_q[NS-2:0], 1'b0};
    end
  end

  // app reset: asserted without clock, released after all causes settle
  always_ff @(posedge MCLK_IN or posedge app_cause) begin
    if (app_cause) begin
      app_rst_q <= {NS{pcrc_pkg::RST_ASSERTED}};
    end else if (SRST_IN) begin
      app_rst_q <= {NS{pcrc_pkg::RST_ASSERTED}};
    end else begin
      app_rst_q <= {app_rst_q[NS-2:0], 1'b0};
    end
  end

  assign CORE_RST_OUT = core_rst_q[NS-1];
  assign APP_RST_OUT = app_rst_q[NS-1];

  // two-flop synchronizers for link status pins
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      link_up_q <= 2'h0;
      inband_q <= 2'h0;
    end else begin
      link_up_q <= {link_up_q[0], LINK_UP_IN};
      inband_q <= {inband_q[0], INBAND_RST_IN};
    end
  end

  // in-band reset indication, masked while the core reset from the fundamental reset pin is asserted
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      inband_rst_q <= 1'b0;
    end else begin
      inband_rst_q <= inband_q[1] && !core_rst_q[NS-1];
    end
  end

  // link bring-up sequencer, starts training on its own
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN || core_rst_q[NS-1]) begin
      state_q <= pcrc_pkg::PCRC_ST_RESET;
      train_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      case (state_q)
        pcrc_pkg::PCRC_ST_RESET: begin
          state_q <= pcrc_pkg::PCRC_ST_TRAIN;
          train_q <= 1'b1;
          active_q <= 1'b0;
        end
        pcrc_pkg::PCRC_ST_TRAIN: begin
          if (link_up_q[1] && !inband_q[1]) begin
            state_q <= pcrc_pkg::PCRC_ST_ACTIVE;
            train_q <= 1'b0;
            active_q <= 1'b1;
          end
        end
        pcrc_pkg::PCRC_ST_ACTIVE: begin
          if (inband_q[1] || !link_up_q[1]) begin
            state_q <= pcrc_pkg::PCRC_ST_TRAIN;
            train_q <= 1'b1;
            active_q <= 1'b0;
          end
        end
        default: begin
          state_q <= pcrc_pkg::PCRC_ST_RESET;
          train_q <= 1'b0;
          active_q <= 1'b0;
        end
      endcase
    end
  end

  // static configuration reported as status
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      slot_q <= 1'b0;
      aspm_q <= 1'b0;
      refclk_q <= pcrc_pkg::REFCLK_CODE_100;
    end else begin
      slot_q <= SLOT_CLOCK_CFG;
      aspm_q <= !NONSYNC_CLOCKING_OPTION;
      refclk_q <= refclk_code(REFCLK_MHZ);
    end
  end

  assign INBAND_RST_OUT = inband_rst_q;
  assign LINK_TRAIN_OUT = train_q;
  assign LINK_ACTIVE_OUT = active_q;
  assign SLOT_CLK_STAT_OUT = slot_q;
  assign ASPM_ALLOWED_OUT = aspm_q;
  assign REFCLK_CODE_OUT = refclk_q;

  // checks
  property p_refclk_legal;
    @(posedge MCLK_IN) disable iff (SRST_IN)
    !$past(SRST_IN) |-> (REFCLK_CODE_OUT == refclk_code(REFCLK_MHZ))
      && (REFCLK_CODE_OUT != 2'h3);
  endproperty
  a_refclk_legal: assert property (p_refclk_legal) else $error("bad refclk code");

  property p_slot_stat;
    @(posedge MCLK_IN) disable iff (SRST_IN)
    !$past(SRST_IN) |-> SLOT_CLK_STAT_OUT == SLOT_CLOCK_CFG;
  endproperty
  a_slot_stat: assert property (p_slot_stat) else $error("slot status wrong");

  property p_core_hard_rst;
    @(posedge MCLK_IN) disable iff (SRST_IN)
    !FUND_RST_N_IN |=> (CORE_RST_OUT && !LINK_TRAIN_OUT)[*2];
  endproperty
  a_core_hard_rst: assert property (p_core_hard_rst) else $error("core not reset");

  property p_auto_train;
    @(posedge MCLK_IN) disable iff (SRST_IN)
    $fell(CORE_RST_OUT) |=> LINK_TRAIN_OUT;
  endproperty
  a_auto_train: assert property (p_auto_train) else $error("no training start");

  property p_inband_flag;
    @(posedge MCLK_IN) disable iff (SRST_IN)
    (inband_q[1] && !CORE_RST_OUT) |=> INBAND_RST_OUT && !LINK_ACTIVE_OUT;
  endproperty
  a_inband_flag: assert property (p_inband_flag) else $error("in-band not flagged");

  property p_app_on_unlock;
    @(posedge MCLK_IN) disable iff (SRST_IN)
    (!CORE_PLL_LOCK_IN || !(&XCVR_PLL_LOCK_IN) || !FUND_RST_N_IN) |=> APP_RST_OUT;
  endproperty
  a_app_on_unlock: assert property (p_app_on_unlock) else $error("app reset missing");

  property p_app_release;
    @(posedge MCLK_IN) disable iff (SRST_IN)
    $fell(APP_RST_OUT) |-> !$past(app_cause) && !$past(app_cause, 2);
  endproperty
  a_app_release: assert property (p_app_release) else $error("early app release");

  property p_app_sync_release;
    @(posedge MCLK_IN) disable iff (SRST_IN)
    (!app_cause && !SRST_IN)[*3] |-> !APP_RST_OUT;
  endproperty
  a_app_sync_release: assert property (p_app_sync_release) else $error("app reset stuck");

  c_link_up: cover property (@(posedge MCLK_IN) disable iff (SRST_IN)
    LINK_TRAIN_OUT ##[1:20] LINK_ACTIVE_OUT);
  c_hot_reset: cover property (@(posedge MCLK_IN) disable iff (SRST_IN)
    LINK_ACTIVE_OUT ##1 INBAND_RST_OUT);
  c_unlock: cover property (@(posedge MCLK_IN) disable iff (SRST_IN)
    !CORE_PLL_LOCK_IN ##1 APP_RST_OUT ##[1:8] !APP_RST_OUT);
endmodule : pcrc_core

/* pcrc_board_model.sv */
// board reset source driving the fundamental reset pin of the core
`timescale 1ns/1ps
module pcrc_board_model (
  input wire logic clk_in,
  input wire logic warm_req_in,
  output logic fund_rst_n_out
);
  int cnt_q = 12;
  logic pin_n_q = 1'h0;
  // low count: power-up and every warm request
  always_ff @(posedge clk_in) begin
    if (warm_req_in) cnt_q <= 6;
    else if (cnt_q != 0) cnt_q <= cnt_q - 1;
  end
  // pin moves off the sampling edge
  always_ff @(negedge clk_in) begin
    pin_n_q <= (cnt_q == 0);
  end
  assign fund_rst_n_out = pin_n_q;
endmodule : pcrc_board_model

/* pcie_core_clock_reset_control_bench.sv */
// self-checking bench for the core clock and reset control block
`timescale 1ns/1ps
module pcie_core_clock_reset_control_bench;
  logic clk = 0, srst = 1, core_lock = 1, link_up = 0, inband = 0, warm = 0, pin_n;
  logic [3:0] xlock = 4'hF;
  logic core_rst, app_rst, inb_out, train, active, slot, aspm;
  logic [1:0] code;
  logic slot2, aspm2;
  logic [1:0] code2;
  int n_errors = 0;
  int n_compared = 0;
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  pcrc_board_model board (.clk_in(clk), .warm_req_in(warm), .fund_rst_n_out(pin_n));
  pcrc_core #(.REFCLK_MHZ(250), .SLOT_CLOCK_CFG(1'b0), .NONSYNC_CLOCKING_OPTION(1'b1)) uut (
    .MCLK_IN(clk), .SRST_IN(srst), .FUND_RST_N_IN(pin_n), .CORE_PLL_LOCK_IN(core_lock),
    .XCVR_PLL_LOCK_IN(xlock), .LINK_UP_IN(link_up), .INBAND_RST_IN(inband),
    .CORE_RST_OUT(core_rst), .APP_RST_OUT(app_rst), .INBAND_RST_OUT(inb_out),
    .LINK_TRAIN_OUT(train), .LINK_ACTIVE_OUT(active), .SLOT_CLK_STAT_OUT(slot),
    .ASPM_ALLOWED_OUT(aspm), .REFCLK_CODE_OUT(code));
  // second build: slot clock, 125 MHz, common clock source
  pcrc_core #(.REFCLK_MHZ(125), .SLOT_CLOCK_CFG(1'b1), .NONSYNC_CLOCKING_OPTION(1'b0)) uut_alt (
    .MCLK_IN(clk), .SRST_IN(srst), .FUND_RST_N_IN(pin_n), .CORE_PLL_LOCK_IN(core_lock),
    .XCVR_PLL_LOCK_IN(xlock), .LINK_UP_IN(link_up), .INBAND_RST_IN(inband),
    .CORE_RST_OUT(), .APP_RST_OUT(), .INBAND_RST_OUT(), .LINK_TRAIN_OUT(), .LINK_ACTIVE_OUT(),
    .SLOT_CLK_STAT_OUT(slot2), .ASPM_ALLOWED_OUT(aspm2), .REFCLK_CODE_OUT(code2));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // bounded wait for a level; sel 0 watches the pin, 1 the link active flag
  task automatic wait_for(input bit sel, input logic v);
    int i;
    for (i = 0; i < 60 && (sel ? active : pin_n) !== v; i++) @(negedge clk);
    if ((sel ? active : pin_n) !== v) begin
      n_errors++;
      report_and_stop();
    end
  endtask : wait_for
  // pin release chain: resets clear, training starts unasked
  task automatic t_release;
    // pin moves on a falling edge, so it is seen one falling edge later
    wait_for(1'b0, 1'b1);
    chk(core_rst, 1);
    cyc(1); chk({core_rst, app_rst}, 0);
    cyc(1); chk(train, 1);
  endtask : t_release
  // lock loss: app reset at once, synchronized release
  task automatic t_lock(input bit on_core);
    if (on_core) core_lock = 0;
    else xlock = 4'hB;
    #1 chk({core_rst, app_rst}, 1);
    cyc(3);
    core_lock = 1;
    xlock = 4'hF;
    cyc(1); chk(app_rst, 1);
    cyc(1); chk(app_rst, 0);
  endtask : t_lock
  // link up then in-band reset
  task automatic t_link_inband;
    link_up = 1;
    cyc(2); chk(active, 0);
    cyc(1); chk({train, active}, 1);
    inband = 1;
    cyc(2); chk(inb_out, 0);
    cyc(1); chk({inb_out, train, active, app_rst, core_rst}, 8'h18);
    inband = 0;
    wait_for(1'b1, 1'b1);
    chk(inb_out, 0);
  endtask : t_link_inband
  // warm reset through the pin
  task automatic t_warm;
    link_up = 0;
    warm = 1;
    cyc(1);
    warm = 0;
    cyc(1); chk({core_rst, app_rst, train, active}, 8'hC);
    t_release();
  endtask : t_warm
  // main sequence
  initial begin
    cyc(8);
    srst = 0;
    cyc(1); chk({slot, aspm, code}, pcrc_pkg::REFCLK_CODE_250);
    chk({slot2, aspm2, code2}, {2'h3, pcrc_pkg::REFCLK_CODE_125});
    chk({core_rst, app_rst}, 3);
    t_release();
    t_lock(1'b0);
    t_lock(1'b1);
    t_link_inband();
    t_warm();
    report_and_stop();
  end
endmodule : pcie_core_clock_reset_control_bench
